// file: blctp_pkg.sv
package blctp_pkg;

    // Pixel and offset widths.
    localparam int PIX_W = 12;
    localparam int AOFS_W = 8;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OFS_G1 = 8'h04;
    localparam logic [7:0] A_OFS_R = 8'h08;
    localparam logic [7:0] A_OFS_B = 8'h0C;
    localparam logic [7:0] A_OFS_G2 = 8'h10;
    localparam logic [7:0] A_GAIN_G = 8'h14;
    localparam logic [7:0] A_GAIN_RB = 8'h18;
    localparam logic [7:0] A_DIG = 8'h1C;
    localparam logic [7:0] A_THR = 8'h20;
    localparam logic [7:0] A_TP_GRN = 8'h24;
    localparam logic [7:0] A_TP_RED = 8'h28;
    localparam logic [7:0] A_TP_BLU = 8'h2C;
    localparam logic [7:0] A_TP_DATA = 8'h30;
    localparam logic [7:0] A_TP_BAR = 8'h34;

    // Control, digital gain and threshold register fields.
    localparam int CTRL_MAN = 0;
    localparam int CTRL_LOCK_G = 1;
    localparam int CTRL_LOCK_RB = 2;
    localparam int CTRL_TP_EN = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int DIG_GAIN_LSB = 16;
    localparam int THR_HI_LSB = 16;

    // Reset values and the black level target.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [11:0] THR_LO_RST = 12'h0A0;
    localparam logic [11:0] THR_HI_RST = 12'h0C0;
    localparam logic [11:0] BLACK_TARGET = 12'h0A8;
    localparam logic [11:0] TP_BAR_RST = 12'h010;

    // Calibration averages 2**CAL_SHIFT dark samples per step.
    localparam int CAL_SHIFT = 4;
    localparam logic signed [7:0] CAL_STEP = 8'sh01;

    // Pattern select codes.
    localparam logic [3:0] TP_FIELD = 4'h0;
    localparam logic [3:0] TP_HGRAD = 4'h1;
    localparam logic [3:0] TP_VGRAD = 4'h2;
    localparam logic [3:0] TP_DGRAD = 4'h3;
    localparam logic [3:0] TP_CLASSIC = 4'h4;
    localparam logic [3:0] TP_WALK = 4'h5;
    localparam logic [3:0] TP_HBARS = 4'h6;
    localparam logic [3:0] TP_VBARS = 4'h7;
    localparam logic [3:0] TP_CBARS = 4'h8;

    typedef enum logic [1:0] {COL_G1, COL_R, COL_B, COL_G2} blctp_colour_type;

    typedef struct packed {
        logic valid;
        logic sof;
        logic sol;
        logic dark_row;
        logic dark_col;
        blctp_colour_type colour;
        logic [11:0] data;
    } blctp_pix_type;

    typedef struct packed {
        logic [3:0] mode;
        logic [11:0] green;
        logic [11:0] red;
        logic [11:0] blue;
        logic [11:0] tdata;
        logic [11:0] bar;
    } blctp_tp_cfg_type;

endpackage : blctp_pkg

// file: blctp_dark_cal.sv
module blctp_dark_cal (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire blctp_pkg::blctp_pix_type pix,
    input wire logic [11:0] thr_lo,
    input wire logic [11:0] thr_hi,
    output logic [3:0][7:0] cal_ofs
);

    logic [15:0] sum_q [4];
    logic [3:0] cnt_q [4];
    logic sample;
    logic [1:0] ch;
    logic [15:0] sum_next;
    logic [11:0] avg;
    logic signed [7:0] cur;

    // Only active columns of dark rows feed the average.
    assign sample = enable & pix.valid & pix.dark_row & ~pix.dark_col;
    assign ch = pix.colour;
    assign sum_next = sum_q[ch] + {4'h0, pix.data};
    assign avg = sum_next[15:blctp_pkg::CAL_SHIFT];
    assign cur = $signed(cal_ofs[ch]);

    // Sample first, then step the offset only when outside the window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                sum_q[i] <= 16'h0000;
                cnt_q[i] <= 4'h0;
                cal_ofs[i] <= 8'h00;
            end
        end else if (sample) begin
            cnt_q[ch] <= cnt_q[ch] + 4'h1;
            if (cnt_q[ch] == 4'hF) begin
                sum_q[ch] <= 16'h0000;
                if (avg < thr_lo && cur != 8'sh7F) begin
                    cal_ofs[ch] <= cur + blctp_pkg::CAL_STEP;
                end else if (avg > thr_hi && cur != -8'sh80) begin
                    cal_ofs[ch] <= cur - blctp_pkg::CAL_STEP;
                end
            end else begin
                sum_q[ch] <= sum_next;
            end
        end
    end

endmodule : blctp_dark_cal

// file: blctp_pattern_gen.sv
module blctp_pattern_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire blctp_pkg::blctp_pix_type pix,
    input wire blctp_pkg::blctp_tp_cfg_type cfg,
    output logic [11:0] value
);

    logic [11:0] h_q, vr_q, cpos_q, rpos_q;
    logic codd_q, rodd_q, ract_q;
    logic [2:0] cidx_q;
    logic [11:0] h_c, v_c, cpos_c, rpos_c;
    logic codd_c, rodd_c, ract_c, rstep, act, cwrap, rwrap;
    logic [2:0] cidx_c, rgb;
    logic [11:0] own, chan;

    // Picks the programmed value that matches the filter colour.
    function automatic logic [11:0] pick(logic [1:0] c,
        logic [11:0] g, logic [11:0] r, logic [11:0] b);
        if (c == 2'(blctp_pkg::COL_R)) return r;
        else if (c == 2'(blctp_pkg::COL_B)) return b;
        else return g;
    endfunction : pick

    // Counters restart at row and frame starts.
    assign act = pix.valid & ~pix.dark_row & ~pix.dark_col;
    assign rstep = pix.valid & pix.sol & ~pix.sof & ract_q;
    assign h_c = (pix.valid & pix.sol) ? 12'h000 : h_q;
    assign cpos_c = (pix.valid & pix.sol) ? 12'h000 : cpos_q;
    assign codd_c = (pix.valid & pix.sol) ? 1'b0 : codd_q;
    assign cidx_c = (pix.valid & pix.sol) ? 3'h0 : cidx_q;
    assign ract_c = (pix.valid & pix.sol) ? 1'b0 : ract_q;
    assign rwrap = rpos_q + 12'h001 >= cfg.bar;
    assign cwrap = cpos_c + 12'h001 >= cfg.bar;
    assign v_c = (pix.valid & pix.sof) ? 12'h000
        : (rstep ? vr_q + 12'h001 : vr_q);
    assign rpos_c = (pix.valid & pix.sof) ? 12'h000
        : (rstep ? (rwrap ? 12'h000 : rpos_q + 12'h001) : rpos_q);
    assign rodd_c = (pix.valid & pix.sof) ? 1'b0
        : (rstep & rwrap ? ~rodd_q : rodd_q);

    // Column counters advance on active pixels; row counters advance at the next row start after a row with active pixels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {h_q, vr_q, cpos_q, rpos_q} <= 48'h0;
            {codd_q, rodd_q, ract_q, cidx_q} <= 6'h00;
        end else begin
            h_q <= act ? h_c + 12'h001 : h_c;
            vr_q <= v_c;
            rpos_q <= rpos_c;
            rodd_q <= rodd_c;
            ract_q <= ract_c | act;
            cpos_q <= act ? (cwrap ? 12'h000 : cpos_c + 12'h001) : cpos_c;
            codd_q <= act & cwrap ? ~codd_c : codd_c;
            cidx_q <= act & cwrap ? cidx_c + 3'h1 : cidx_c;
        end
    end

    // Colour bar table: white, yellow, cyan, green, magenta, red, blue, black.
    assign rgb = 3'h7 - {cidx_c[1], cidx_c[2], cidx_c[0]};
    assign own = pick(pix.colour, cfg.green, cfg.red, cfg.blue);
    assign chan = (pix.colour == blctp_pkg::COL_R) ? {12{rgb[2]}}
        : (pix.colour == blctp_pkg::COL_B) ? {12{rgb[0]}} : {12{rgb[1]}};

    // One pattern at a time; dark pixels take their colour value.
    always_comb begin
        value = own;
        if (act) begin
            case (cfg.mode)
                blctp_pkg::TP_HGRAD: value = h_c;
                blctp_pkg::TP_VGRAD: value = v_c;
                blctp_pkg::TP_DGRAD: value = h_c + v_c;
                blctp_pkg::TP_CLASSIC: value = h_c[0] ? ~cfg.tdata
                    : cfg.tdata;
                blctp_pkg::TP_WALK: value = 12'h001 << (h_c % 12);
                blctp_pkg::TP_HBARS: value = rodd_c ? cfg.blue
                    : cfg.green;
                blctp_pkg::TP_VBARS: value = codd_c ? cfg.blue
                    : cfg.green;
                blctp_pkg::TP_CBARS: value = chan;
                default: value = own;
            endcase
        end
    end

endmodule : blctp_pattern_gen

// file: blctp_top.sv
module blctp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire blctp_pkg::blctp_pix_type pix_in,
    output blctp_pkg::blctp_pix_type pix_out,
    output logic [3:0][7:0] analog_ofs
);

    logic [7:0] ctrl_q;
    logic [3:0][7:0] prog_q;
    logic [3:0][7:0] use_q;
    logic [3:0][7:0] eff;
    logic [3:0][7:0] cal_ofs;
    logic [15:0] gain_g_q;
    logic [15:0] gain_rb_q;
    logic [11:0] dofs_q;
    logic [6:0] dgain_q;
    logic [11:0] thr_lo_q;
    logic [11:0] thr_hi_q;
    logic [11:0] tp_grn_q;
    logic [11:0] tp_red_q;
    logic [11:0] tp_blu_q;
    logic [11:0] tp_data_q;
    logic [11:0] tp_bar_q;
    logic man_prev_q;
    logic [31:0] prdata_q;
    blctp_pkg::blctp_pix_type head_q;
    blctp_pkg::blctp_pix_type out_q;
    blctp_pkg::blctp_tp_cfg_type tp_cfg;
    logic [11:0] tp_value;

    logic manual;
    logic enter_manual;
    logic lock_g;
    logic lock_rb;
    logic tp_en;
    logic setup;
    logic wr;
    logic hit;
    logic [3:0] wr_ofs;
    logic [31:0] rd_mux;
    logic [11:0] corrected;

    // Gain-aware digital black level correction with clamping.
    function automatic logic [11:0] correct(logic [11:0] x,
        logic [6:0] g, logic [11:0] ofs);
        logic signed [13:0] d;
        logic signed [22:0] p;
        logic signed [22:0] s;
        d = $signed({2'b00, x}) - $signed({2'b00, blctp_pkg::BLACK_TARGET});
        p = 23'(d) * $signed({15'h0000, 8'({1'b0, g} + 8'h08)});
        s = (p >>> 3) + $signed({11'h000, blctp_pkg::BLACK_TARGET})
            + 23'($signed(ofs));
        if (s < 0) begin
            return 12'h000;
        end else if (s > 23'sh000FFF) begin
            return 12'hFFF;
        end else begin
            return s[11:0];
        end
    endfunction : correct

    // Control field breakout.
    assign manual = ctrl_q[blctp_pkg::CTRL_MAN];
    assign lock_g = ctrl_q[blctp_pkg::CTRL_LOCK_G];
    assign lock_rb = ctrl_q[blctp_pkg::CTRL_LOCK_RB];
    assign tp_en = ctrl_q[blctp_pkg::CTRL_TP_EN];
    assign enter_manual = manual & ~man_prev_q;

    // APB phase decode; the slave always answers without wait states.
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;

    // Offset writes per colour channel.
    assign wr_ofs[blctp_pkg::COL_G1] = wr && paddr == blctp_pkg::A_OFS_G1;
    assign wr_ofs[blctp_pkg::COL_R] = wr && paddr == blctp_pkg::A_OFS_R;
    assign wr_ofs[blctp_pkg::COL_B] = wr && paddr == blctp_pkg::A_OFS_B;
    assign wr_ofs[blctp_pkg::COL_G2] = wr && paddr == blctp_pkg::A_OFS_G2;

    // Paired channels share one offset when locked and gains match.
    assign eff[blctp_pkg::COL_G1] = use_q[blctp_pkg::COL_G1];
    assign eff[blctp_pkg::COL_R] = use_q[blctp_pkg::COL_R];
    assign eff[blctp_pkg::COL_G2] =
        (lock_g && gain_g_q[7:0] == gain_g_q[15:8])
        ? use_q[blctp_pkg::COL_G1] : use_q[blctp_pkg::COL_G2];
    assign eff[blctp_pkg::COL_B] =
        (lock_rb && gain_rb_q[7:0] == gain_rb_q[15:8])
        ? use_q[blctp_pkg::COL_R] : use_q[blctp_pkg::COL_B];

    // Read selection; offsets read back the value in use.
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == blctp_pkg::A_CTRL) begin
            rd_mux = {24'h00_0000, ctrl_q};
        end else if (paddr == blctp_pkg::A_OFS_G1) begin
            rd_mux = {24'h00_0000, eff[blctp_pkg::COL_G1]};
        end else if (paddr == blctp_pkg::A_OFS_R) begin
            rd_mux = {24'h00_0000, eff[blctp_pkg::COL_R]};
        end else if (paddr == blctp_pkg::A_OFS_B) begin
            rd_mux = {24'h00_0000, eff[blctp_pkg::COL_B]};
        end else if (paddr == blctp_pkg::A_OFS_G2) begin
            rd_mux = {24'h00_0000, eff[blctp_pkg::COL_G2]};
        end else if (paddr == blctp_pkg::A_GAIN_G) begin
            rd_mux = {16'h0000, gain_g_q};
        end else if (paddr == blctp_pkg::A_GAIN_RB) begin
            rd_mux = {16'h0000, gain_rb_q};
        end else if (paddr == blctp_pkg::A_DIG) begin
            rd_mux = {9'h000, dgain_q, 4'h0, dofs_q};
        end else if (paddr == blctp_pkg::A_THR) begin
            rd_mux = {4'h0, thr_hi_q, 4'h0, thr_lo_q};
        end else if (paddr == blctp_pkg::A_TP_GRN) begin
            rd_mux = {20'h0_0000, tp_grn_q};
        end else if (paddr == blctp_pkg::A_TP_RED) begin
            rd_mux = {20'h0_0000, tp_red_q};
        end else if (paddr == blctp_pkg::A_TP_BLU) begin
            rd_mux = {20'h0_0000, tp_blu_q};
        end else if (paddr == blctp_pkg::A_TP_DATA) begin
            rd_mux = {20'h0_0000, tp_data_q};
        end else if (paddr == blctp_pkg::A_TP_BAR) begin
            rd_mux = {20'h0_0000, tp_bar_q};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data is captured in the setup phase and held for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

    // Configuration registers written in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= blctp_pkg::CTRL_RST;
            gain_g_q <= 16'h0000;
            gain_rb_q <= 16'h0000;
            dofs_q <= 12'h000;
            dgain_q <= 7'h00;
            thr_lo_q <= blctp_pkg::THR_LO_RST;
            thr_hi_q <= blctp_pkg::THR_HI_RST;
        end else if (wr) begin
            if (paddr == blctp_pkg::A_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == blctp_pkg::A_GAIN_G) begin
                gain_g_q <= pwdata[15:0];
            end
            if (paddr == blctp_pkg::A_GAIN_RB) begin
                gain_rb_q <= pwdata[15:0];
            end
            if (paddr == blctp_pkg::A_DIG) begin
                dofs_q <= pwdata[11:0];
                dgain_q <= pwdata[blctp_pkg::DIG_GAIN_LSB +: 7];
            end
            if (paddr == blctp_pkg::A_THR) begin
                thr_lo_q <= pwdata[11:0];
                thr_hi_q <= pwdata[blctp_pkg::THR_HI_LSB +: 12];
            end
        end
    end

    // Test pattern registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tp_grn_q <= 12'h000;
            tp_red_q <= 12'h000;
            tp_blu_q <= 12'h000;
            tp_data_q <= 12'h000;
            tp_bar_q <= blctp_pkg::TP_BAR_RST;
        end else if (wr) begin
            if (paddr == blctp_pkg::A_TP_GRN) begin
                tp_grn_q <= pwdata[11:0];
            end
            if (paddr == blctp_pkg::A_TP_RED) begin
                tp_red_q <= pwdata[11:0];
            end
            if (paddr == blctp_pkg::A_TP_BLU) begin
                tp_blu_q <= pwdata[11:0];
            end
            if (paddr == blctp_pkg::A_TP_DATA) begin
                tp_data_q <= pwdata[11:0];
            end
            if (paddr == blctp_pkg::A_TP_BAR) begin
                tp_bar_q <= pwdata[11:0];
            end
        end
    end

    // Programmed offsets are always stored, whatever the mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_q <= 32'h0000_0000;
            man_prev_q <= 1'b0;
        end else begin
            man_prev_q <= manual;
            for (int c = 0; c < 4; c++) begin
                if (wr_ofs[c]) begin
                    prog_q[c] <= pwdata[7:0];
                end
            end
        end
    end

    // Offsets in use follow calibration, or the programmed value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_q <= 32'h0000_0000;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (!manual) begin
                    use_q[c] <= cal_ofs[c];
                end else if (wr_ofs[c]) begin
                    use_q[c] <= pwdata[7:0];
                end else if (enter_manual) begin
                    use_q[c] <= prog_q[c];
                end
            end
        end
    end

    // Analog offsets are driven from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ofs <= 32'h0000_0000;
        end else begin
            analog_ofs <= eff;
        end
    end

    // Dark-row calibration runs only outside manual mode.
    blctp_dark_cal u_cal (
        .pclk(pclk),
        .presetn(presetn),
        .enable(~manual),
        .pix(pix_in),
        .thr_lo(thr_lo_q),
        .thr_hi(thr_hi_q),
        .cal_ofs(cal_ofs)
    );

    // Pattern generator configuration.
    assign tp_cfg.mode = ctrl_q[blctp_pkg::CTRL_MODE_LSB +: 4];
    assign tp_cfg.green = tp_grn_q;
    assign tp_cfg.red = tp_red_q;
    assign tp_cfg.blue = tp_blu_q;
    assign tp_cfg.tdata = tp_data_q;
    assign tp_cfg.bar = tp_bar_q;

    blctp_pattern_gen u_tp (
        .pclk(pclk),
        .presetn(presetn),
        .pix(pix_in),
        .cfg(tp_cfg),
        .value(tp_value)
    );

    // Head of the datapath: the pattern replaces sensor samples.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_q <= '0;
        end else begin
            head_q <= pix_in;
            if (tp_en) begin
                head_q.data <= tp_value;
            end
        end
    end

    // Correction touches active columns of every row, dark rows too.
    assign corrected = head_q.dark_col ? head_q.data
        : correct(head_q.data, dgain_q, dofs_q);

    // Final stage feeds the output pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q <= head_q;
            out_q.data <= corrected;
        end
    end

    assign pix_out = out_q;

endmodule : blctp_top

// file: blctp_chk.sv
module blctp_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire blctp_pkg::blctp_pix_type pix_in,
    input wire blctp_pkg::blctp_pix_type pix_out,
    input wire logic [3:0][7:0] analog_ofs
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Flags addresses outside the register map or not word aligned.
    logic bad;
    assign bad = (paddr > 8'h34) || (paddr[1:0] != 2'h0);
    sequence acc_s;
        psel && penable;
    endsequence
    ready_high_a: assert property (acc_s |-> pready)
        else $error("pready low in access");
    err_unmap_a: assert property (acc_s ##0 bad |-> pslverr)
        else $error("unmapped access without error");
    err_map_a: assert property (acc_s ##0 !bad |-> !pslverr)
        else $error("mapped access flagged");
    err_idle_a: assert property (!penable |-> !pslverr)
        else $error("error outside access phase");
    rd_zero_a: assert property (acc_s ##0 (bad && !pwrite) |-> prdata == 0)
        else $error("unmapped read not zero");
    lat_valid_a: assert property (pix_in.valid |-> ##2 pix_out.valid)
        else $error("pixel lost");
    lat_idle_a: assert property (!pix_in.valid |-> ##2 !pix_out.valid)
        else $error("pixel invented");
    colour_keep_a: assert property (pix_in.valid |-> ##2
        (pix_out.colour == $past(pix_in.colour, 2)
        && pix_out.sof == $past(pix_in.sof, 2)))
        else $error("pixel colour or frame mark changed");
    // Offsets move only after a pixel sample or a register access.
    ofs_quiet_a: assert property (!$past(pix_in.valid, 3)
        && !$past(psel, 2) && !$past(psel, 3) |-> $stable(analog_ofs))
        else $error("analog offset moved without cause");
endmodule : blctp_chk

bind blctp_top blctp_chk i_blctp_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in(pix_in), .pix_out(pix_out), .analog_ofs(analog_ofs));

// file: blctp_sink.sv
module blctp_sink (
    input wire logic pclk,
    input wire blctp_pkg::blctp_pix_type pix
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] got [0:511];
    int n_got = 0;
    // Stores every valid pixel in order; this stream has no back-pressure.
    always @(posedge pclk) begin
        if (pix.valid) begin
            got[n_got] <= pix.data;
            n_got <= n_got + 1;
        end
    end
endmodule : blctp_sink

// file: blctp_top_test.sv
module blctp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    blctp_pkg::blctp_pix_type pix_in = '0;
    blctp_pkg::blctp_pix_type pix_out;
    logic [3:0][7:0] analog_ofs;
    logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
        4'h7, 4'h8, 4'h9};
    int n_fail = 0;
    int total_checks = 0;
    always #2 pclk = ~pclk;
    blctp_top i_blctp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pix_in(pix_in), .pix_out(pix_out), .analog_ofs(analog_ofs));
    blctp_sink i_blctp_sink (.pclk(pclk), .pix(pix_out));
    task end_of_test;
        $display("Checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e, "read");
    endtask : rdc
    task px(input logic [1:0] c, input logic [11:0] d, input logic dr,
            input logic dc, input logic f, input logic s);
        pix_in <= '{1'b1, f, s, dr, dc, blctp_pkg::blctp_colour_type'(c), d};
        @(posedge pclk);
    endtask : px
    task idle;
        pix_in.valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : idle
    task ofs(input int c, input logic [7:0] e);
        repeat (3) @(posedge pclk);
        chk(analog_ofs[c], e, "analog offset");
    endtask : ofs
    // Expected value at column c of row r; even columns green, odd red.
    function automatic logic [11:0] pat(input logic [3:0] m, input int c,
            input int r);
        case (m)
            4'h1: pat = 12'(c);
            4'h2: pat = 12'(r);
            4'h3: pat = 12'(c + r);
            4'h4: pat = c % 2 ? 12'hA5A : 12'h5A5;
            4'h5: pat = 12'h001 << (c % 12);
            4'h6: pat = (r / 2) % 2 ? 12'h333 : 12'h111;
            4'h7: pat = (c / 2) % 2 ? 12'h333 : 12'h111;
            4'h8: pat = c % 2 && c > 3 ? 12'h000 : 12'hFFF;
            default: pat = c % 2 ? 12'h222 : 12'h111;
        endcase
    endfunction : pat
    task row(input logic en, input logic [3:0] m, input int r);
        int b;
        b = i_blctp_sink.n_got;
        for (int i = 0; i < 8; i++)
            px(2'(i % 2), 12'h080 + 12'(i), 1'b0, 1'b0, r == 0 && i == 0,
                i == 0);
        idle();
        for (int i = 0; i < 8; i++)
            chk(i_blctp_sink.got[b + i], en ? pat(m, i, r)
                : 12'h080 + 12'(i), "pixel");
    endtask : row
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    initial begin
        logic [11:0] cd [3] = '{12'h000, 12'h0B0, 12'hFFF};
        logic [7:0] ce [3] = '{8'h01, 8'h00, 8'hFF};
        int b;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(blctp_pkg::A_CTRL, 32'h0);
        rdc(blctp_pkg::A_THR, 32'h00C0_00A0);
        rdc(blctp_pkg::A_TP_BAR, 32'h10);
        rdc(8'h40, 32'h0);
        chk(err, 1'b1, "unmapped error");
        $display("Test registers done");
        for (int c = 0; c < 3; c++) begin
            for (int i = 0; i < 16; i++)
                px(2'(c), cd[c], 1'b1, 1'b0, i == 0, i == 0);
            idle();
            chk(analog_ofs[c], ce[c], "calibration");
        end
        rdc(blctp_pkg::A_OFS_G1, 32'h01);
        wr(blctp_pkg::A_OFS_G1, 32'h20);
        ofs(0, 8'h01);
        wr(blctp_pkg::A_CTRL, 32'h01);
        ofs(0, 8'h20);
        wr(blctp_pkg::A_OFS_R, 32'h33);
        ofs(1, 8'h33);
        rdc(blctp_pkg::A_OFS_R, 32'h33);
        for (int i = 0; i < 16; i++)
            px(2'h0, 12'h000, 1'b1, 1'b0, i == 0, i == 0);
        idle();
        ofs(0, 8'h20);
        $display("Test offsets done");
        wr(blctp_pkg::A_OFS_G2, 32'h05);
        wr(blctp_pkg::A_CTRL, 32'h03);
        ofs(3, 8'h20);
        rdc(blctp_pkg::A_OFS_G2, 32'h20);
        wr(blctp_pkg::A_GAIN_G, 32'h0100);
        ofs(3, 8'h05);
        wr(blctp_pkg::A_CTRL, 32'h05);
        ofs(2, 8'h33);
        $display("Test locking done");
        wr(blctp_pkg::A_DIG, 32'h0008_0FF8);
        b = i_blctp_sink.n_got;
        px(2'h0, 12'h100, 1'b0, 1'b0, 1'b1, 1'b1);
        px(2'h0, 12'h100, 1'b0, 1'b1, 1'b0, 1'b0);
        idle();
        chk(i_blctp_sink.got[b], 12'h150, "digital");
        chk(i_blctp_sink.got[b + 1], 12'h100, "dark column");
        wr(blctp_pkg::A_DIG, 32'h0);
        $display("Test digital done");
        wr(blctp_pkg::A_TP_GRN, 32'h111);
        wr(blctp_pkg::A_TP_RED, 32'h222);
        wr(blctp_pkg::A_TP_BLU, 32'h333);
        wr(blctp_pkg::A_TP_DATA, 32'h5A5);
        wr(blctp_pkg::A_TP_BAR, 32'h2);
        foreach (modes[k]) begin
            wr(blctp_pkg::A_CTRL, {modes[k], 4'h9});
            for (int r = 0; r < 3; r++)
                row(1'b1, modes[k], r);
        end
        wr(blctp_pkg::A_CTRL, 32'h01);
        row(1'b0, 4'h0, 0);
        $display("Test patterns done");
        end_of_test();
    end
endmodule : blctp_top_test
